// *** dv/vak_checker.sv ***
`timescale 1ns/1ps
// Port-level checks of the keypad settings block
module vak_checker
  import vak_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        loop_mode,
  input wire logic [7:0]  loop_current_dma,
  input wire logic [3:0]  disp_tens,
  input wire logic [3:0]  disp_units,
  input wire logic        disp_show_name,
  input wire logic [2:0]  disp_name,
  input wire logic [11:0] coil_current_ma,
  input wire logic [8:0]  pwm_freq_hz,
  input wire logic        drive_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Broken loop and the error picture it must leave
  sequence s_break;
    loop_mode && (loop_current_dma < LOOP_BREAK_DMA);
  endsequence
  sequence s_err_shown;
    disp_show_name && (disp_name == NM_ERROR);
  endsequence

  a_rdata_idle: assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not cleared");
  a_unmapped_read: assert property
    (ce && reg_rd && reg_addr > ADDR_STATE |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_break_latch: assert property (s_break |-> ##[1:3] !drive_enable)
    else $error("cable break not latched");
  a_drive_held: assert property ($fell(drive_enable) |=> !drive_enable [*8])
    else $error("drive came back after break");
  a_error_shown: assert property ($fell(drive_enable) |-> ##[0:2] s_err_shown)
    else $error("error name missing");
  a_error_hold: assert property (s_err_shown |=> s_err_shown)
    else $error("error name dropped");
  a_pwm_range: assert property
    (pwm_freq_hz >= PWM_MIN_HZ && pwm_freq_hz <= PWM_MAX_HZ)
    else $error("pwm out of range");
  a_coil_limit: assert property (coil_current_ma <= RATED_MAX_MA)
    else $error("coil above rating");
  a_digit_range: assert property
    (!disp_show_name |-> disp_tens <= 4'h9 && disp_units <= 4'h9)
    else $error("digit not decimal");
  c_break: cover property (s_break);
endmodule

bind vak_settings vak_checker i_vak_checker (.clock, .rst, .ce, .reg_addr,
  .reg_rd, .reg_rdata, .loop_mode, .loop_current_dma, .disp_tens, .disp_units,
  .disp_show_name, .disp_name, .coil_current_ma, .pwm_freq_hz, .drive_enable);

// *** dv/vak_operator.sv ***
`timescale 1ns/1ps
// Operator at the front panel: holds keys for whole ms ticks
module vak_operator #(
  parameter int TICK = 4
) (
  input  wire logic clock,
  output logic      key_one,
  output logic      key_two
);
  // Keys up at power-up
  initial begin
    key_one = 1'b0;
    key_two = 1'b0;
  end
  // Press, let go, then pause so each release is seen on its own
  task automatic press(input logic k1, input logic k2, input int ticks);
    @(posedge clock);
    key_one <= k1;
    key_two <= k2;
    repeat (ticks * TICK) @(posedge clock);
    key_one <= 1'b0;
    key_two <= 1'b0;
    repeat (10 * TICK) @(posedge clock);
  endtask
endmodule

// *** dv/vak_settings_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench for the keypad settings block
module vak_settings_tb;
  import vak_pkg::*;
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: check %0d", $time, check_count); end end
  localparam int TK = 4; // Short tick keeps multi-second holds cheap
  logic        clock, rst, ce, loop_mode, reg_wr, reg_rd, irq, disp_blank;
  logic        disp_point_tens, disp_point_units, disp_show_name;
  logic        drive_enable, key_one, key_two;
  logic [9:0]  ref_permil;
  logic [7:0]  loop_current_dma, reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [3:0]  disp_tens, disp_units;
  logic [2:0]  disp_name;
  logic [11:0] coil_current_ma;
  logic [8:0]  pwm_freq_hz;
  int          failures, check_count;

  vak_settings #(.TICK_CYC(TK)) i_vak_settings (.clock, .rst, .ce, .key_one,
    .key_two, .ref_permil, .loop_mode, .loop_current_dma, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .disp_tens, .disp_units,
    .disp_point_tens, .disp_point_units, .disp_show_name, .disp_name,
    .disp_blank, .coil_current_ma, .pwm_freq_hz, .drive_enable);
  vak_operator #(.TICK(TK)) i_vak_operator (.clock, .key_one, .key_two);

  // Register bus cycles, strobes one cycle long
  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic reg_read(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic t_power_up;
    @(posedge clock);
    #1;
    `CHK({disp_show_name, disp_name}, {1'b1, NM_REFERENCE})
    `CHK(pwm_freq_hz, PWM_DEFAULT_HZ)
    repeat (1005 * TK) @(posedge clock);
    #1;
    `CHK({disp_show_name, disp_tens, disp_units}, 9'h060)
  endtask

  task automatic t_view;
    @(posedge clock) loop_mode <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    `CHK({disp_tens, disp_units, disp_point_tens}, 9'h0A1)
    `CHK(coil_current_ma, 12'h514)
    @(posedge clock) ref_permil <= 10'h3E8;
    repeat (3) @(posedge clock);
    #1;
    `CHK({disp_tens, disp_units}, 8'h10)
    `CHK({disp_point_tens, disp_point_units}, 2'b01)
    `CHK(coil_current_ma, RATED_MAX_MA)
    @(posedge clock) ref_permil <= 10'h00A;
    repeat (3) @(posedge clock);
    #1;
    `CHK(coil_current_ma, 12'h000)
    @(posedge clock) ref_permil <= 10'h1F4;
    repeat (2) @(posedge clock);
    #1;
    `CHK(coil_current_ma, 12'h514)
    i_vak_operator.press(1'b1, 1'b0, 20);
    #1;
    `CHK({disp_show_name, disp_name}, {1'b1, NM_REQUIRED})
    repeat (1000 * TK) @(posedge clock);
    #1;
    `CHK({disp_show_name, disp_tens, disp_units}, 9'h013)
    i_vak_operator.press(1'b1, 1'b0, 20);
    #1;
    `CHK(disp_name, NM_REFERENCE)
  endtask

  // Edit entry doubles as the interrupt source for mask and clear
  task automatic t_edit;
    vak_name_t seq [4] = '{NM_OFFSET, NM_RISE, NM_FALL, NM_PWM};
    i_vak_operator.press(1'b0, 1'b1, 3010);
    #1;
    `CHK({disp_show_name, disp_name}, {1'b1, NM_GAIN})
    reg_read(ADDR_STATE);
    `CHK(d[2:0], VAK_EDIT)
    `CHK(irq, 1'b0)
    reg_write(ADDR_MASK, 32'h4);
    `CHK(irq, 1'b1)
    reg_write(ADDR_STATUS, 32'h4);
    `CHK(irq, 1'b0)
    reg_read(ADDR_MASK);
    `CHK(d, 32'h4)
    reg_read(8'h10);
    `CHK(d, 32'h0)
    for (int i = 0; i < 4; i++) begin
      i_vak_operator.press(1'b0, 1'b1, 20);
      #1;
      `CHK(disp_name, seq[i])
    end
  endtask

  // Six steps down hit the floor, one up, then store
  task automatic t_modify;
    logic b;
    i_vak_operator.press(1'b1, 1'b0, 2010);
    reg_read(ADDR_STATE);
    `CHK(d[2:0], VAK_MODIFY)
    repeat (250 * TK) @(posedge clock);
    #1 b = disp_blank;
    repeat (BLINK_MS * TK) @(posedge clock);
    #1;
    `CHK(disp_blank ^ b, 1'b1)
    repeat (6) i_vak_operator.press(1'b1, 1'b0, 20);
    i_vak_operator.press(1'b0, 1'b1, 20);
    i_vak_operator.press(1'b1, 1'b1, 20);
    #1;
    `CHK(pwm_freq_hz, PWM_MIN_HZ[8:0] + PWM_STEP_HZ[8:0])
    `CHK(disp_blank, 1'b0)
    reg_read(ADDR_STATUS);
    `CHK(d[EV_STORED], 1'b1)
    i_vak_operator.press(1'b0, 1'b1, 20);
    #1;
    `CHK(disp_name, NM_GAIN)
  endtask

  // One second rise ramp, frozen halfway by the clock enable
  task automatic t_ramp;
    logic [11:0] c;
    repeat (2) i_vak_operator.press(1'b0, 1'b1, 20);
    i_vak_operator.press(1'b1, 1'b0, 2010);
    i_vak_operator.press(1'b0, 1'b1, 20);
    i_vak_operator.press(1'b1, 1'b1, 20);
    #1;
    `CHK({disp_show_name, disp_tens, disp_units}, 9'h001)
    @(posedge clock) ref_permil <= 10'h3E8;
    repeat (250 * TK) @(posedge clock);
    #1 c = coil_current_ma;
    `CHK(c > 12'h76C && c < 12'h7D0, 1'b1)
    @(posedge clock) ce <= 1'b0;
    @(posedge clock);
    #1 c = coil_current_ma;
    repeat (100 * TK) @(posedge clock);
    #1;
    `CHK(coil_current_ma, c)
    @(posedge clock) ce <= 1'b1;
    repeat (300 * TK) @(posedge clock);
    #1;
    `CHK(coil_current_ma, RATED_MAX_MA)
    @(posedge clock) ref_permil <= 10'h1F4;
    repeat (3) @(posedge clock);
    #1;
    `CHK(coil_current_ma, 12'h514)
  endtask

  task automatic t_break;
    @(posedge clock) begin
      loop_mode <= 1'b1;
      loop_current_dma <= 8'h1D;
    end
    repeat (4) @(posedge clock);
    #1;
    `CHK({drive_enable, disp_show_name, disp_name}, {2'b01, NM_ERROR})
    @(posedge clock) loop_current_dma <= 8'h78;
    reg_write(ADDR_STATUS, 32'h1);
    reg_read(ADDR_STATUS);
    `CHK({d[EV_BREAK], drive_enable}, 2'b00)
  endtask

  task automatic summarize;
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Clock at 200 MHz
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Hang guard, about twice the expected run
  initial begin
    #450000;
    failures++;
    summarize;
  end
  initial begin
    {rst, ce, loop_mode, reg_wr, reg_rd} = 5'b11100;
    loop_current_dma = 8'h78;
    ref_permil = 10'h1F4;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    failures = 0;
    check_count = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_power_up;
    t_view;
    t_edit;
    t_modify;
    t_ramp;
    t_break;
    summarize;
  end
endmodule

// *** include/vak_pkg.sv ***
package vak_pkg;

  // Clock and time base
  localparam int          CLK_HZ          = 200_000_000;
  localparam int          TICK_PER_S      = 1000;
  localparam int          TICK_CYCLES     = CLK_HZ / TICK_PER_S;
  localparam logic [11:0] NAME_MS         = 12'h3E8;
  localparam logic [11:0] EDIT_HOLD_MS    = 12'hBB8;
  localparam logic [11:0] MOD_HOLD_MS     = 12'h7D0;
  localparam logic [11:0] BLINK_MS        = 12'h1F4;

  // Version defaults
  localparam logic [11:0] RATED_MAX_MA    = 12'hA28;
  localparam logic [8:0]  PWM_DEFAULT_HZ  = 9'h064;

  // Parameter limits and steps
  localparam logic [11:0] CUR_STEP_MA     = 12'h064;
  localparam logic [11:0] RAMP_MAX_S      = 12'h032;
  localparam logic [11:0] PWM_MIN_HZ      = 12'h032;
  localparam logic [11:0] PWM_MAX_HZ      = 12'h1F4;
  localparam logic [11:0] PWM_STEP_HZ     = 12'h00A;

  // Reference scaling in per mille of full scale; current-loop break level and loop display range
  localparam logic [9:0]  REF_FULL        = 10'h3E8;
  localparam logic [9:0]  REF_DEAD        = 10'h00A;
  localparam logic [7:0]  LOOP_BREAK_DMA  = 8'h1E;
  localparam logic [6:0]  LOOP_DISP_BASE  = 7'h14;
  localparam logic [6:0]  LOOP_DISP_SPAN  = 7'h50;

  // Register map
  localparam logic [7:0]  ADDR_STATUS     = 8'h00;
  localparam logic [7:0]  ADDR_MASK       = 8'h04;
  localparam logic [7:0]  ADDR_OUTPUT     = 8'h08;
  localparam logic [7:0]  ADDR_STATE      = 8'h0C;
  localparam int          EV_BREAK        = 0;
  localparam int          EV_STORED       = 1;
  localparam int          EV_EDIT         = 2;
  localparam int          EV_NUM          = 3;
  localparam logic [2:0]  MASK_RESET      = 3'h0;

  // Operating modes
  typedef enum logic [2:0] {
    VAK_VIEW   = 3'b001,
    VAK_EDIT   = 3'b010,
    VAK_MODIFY = 3'b100
  } vak_mode_t;

  // Names shown on the display
  typedef enum logic [2:0] {
    NM_REFERENCE = 3'h0,
    NM_REQUIRED  = 3'h1,
    NM_GAIN      = 3'h2,
    NM_OFFSET    = 3'h3,
    NM_RISE      = 3'h4,
    NM_FALL      = 3'h5,
    NM_PWM       = 3'h6,
    NM_ERROR     = 3'h7
  } vak_name_t;

endpackage

// *** rtl/vak_key.sv ***
`timescale 1ns/1ps
// One front key: press timing against a hold threshold in ms ticks
module vak_key
  import vak_pkg::*;
#(
  parameter logic [11:0] HOLD_MS = 12'h7D0
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic tick,
  input  wire logic key,
  output logic      long_hit,
  output logic      short_rel
);

  logic        key_d_r;
  logic [11:0] cnt_r;
  logic        rise;

  assign rise      = key & ~key_d_r;
  // Pulse once when the hold time is reached, not again while held
  assign long_hit  = ce & key & ~rise & tick & (cnt_r == HOLD_MS - 12'h001);
  // Release before the hold time counts as a brief press
  assign short_rel = ce & ~key & key_d_r & (cnt_r < HOLD_MS);

  // Hold counter saturates so a very long press never wraps into a short one
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      key_d_r <= 1'b0;
      cnt_r   <= 12'h000;
    end else if (ce) begin
      key_d_r <= key;
      if (rise) begin
        cnt_r <= 12'h000;
      end else if (key && tick && cnt_r != 12'hFFF) begin
        cnt_r <= cnt_r + 12'h001;
      end
    end
  end

endmodule

// *** rtl/vak_settings.sv ***
`timescale 1ns/1ps
// Operator adjustment logic: two keys, two-digit display, parameters, ramp
module vak_settings
  import vak_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        key_one,
  input  wire logic        key_two,
  input  wire logic [9:0]  ref_permil,
  input  wire logic        loop_mode,
  input  wire logic [7:0]  loop_current_dma,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  output logic      [3:0]  disp_tens,
  output logic      [3:0]  disp_units,
  output logic             disp_point_tens,
  output logic             disp_point_units,
  output logic             disp_show_name,
  output logic      [2:0]  disp_name,
  output logic             disp_blank,
  output logic      [11:0] coil_current_ma,
  output logic      [8:0]  pwm_freq_hz,
  output logic             drive_enable
);

  // Millisecond tick
  logic [17:0] tick_cnt_r;
  logic        tick;
  assign tick = ce & (tick_cnt_r == 18'(TICK_CYC - 1));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= 18'h00000;
    end else if (ce) begin
      tick_cnt_r <= tick ? 18'h00000 : tick_cnt_r + 18'h00001;
    end
  end

  // Key timing
  logic k1_long, k1_short, k2_long, k2_short;
  vak_key #(.HOLD_MS(MOD_HOLD_MS)) u_key_one (
    .clock     (clock),
    .rst       (rst),
    .ce        (ce),
    .tick      (tick),
    .key       (key_one),
    .long_hit  (k1_long),
    .short_rel (k1_short)
  );
  vak_key #(.HOLD_MS(EDIT_HOLD_MS)) u_key_two (
    .clock     (clock),
    .rst       (rst),
    .ce        (ce),
    .tick      (tick),
    .key       (key_two),
    .long_hit  (k2_long),
    .short_rel (k2_short)
  );

  // State
  vak_mode_t   mode_r, mode_nxt;
  logic        var_sel_r;
  logic [2:0]  par_sel_r;
  logic [11:0] gain_r, offset_r, pwm_r;
  logic [11:0] rise_r, fall_r;
  logic [11:0] edit_r;
  logic        both_r, both_seen_r;
  logic        err_r;
  logic [11:0] name_cnt_r, blink_cnt_r;
  logic        blink_r;
  logic [21:0] sp_ua_r;
  logic [EV_NUM-1:0] status_r, mask_r;

  // Parameter helpers: limits and step of each parameter
  function automatic logic [11:0] par_lo(input logic [2:0] s);
    unique case (s)
      3'h0:    par_lo = RATED_MAX_MA >> 1;
      3'h4:    par_lo = PWM_MIN_HZ;
      default: par_lo = 12'h000;
    endcase
  endfunction
  function automatic logic [11:0] par_hi(input logic [2:0] s);
    unique case (s)
      3'h0:    par_hi = RATED_MAX_MA;
      3'h1:    par_hi = RATED_MAX_MA >> 1;
      3'h4:    par_hi = PWM_MAX_HZ;
      default: par_hi = RAMP_MAX_S;
    endcase
  endfunction
  function automatic logic [11:0] par_step(input logic [2:0] s);
    unique case (s)
      3'h0, 3'h1: par_step = CUR_STEP_MA;
      3'h4:       par_step = PWM_STEP_HZ;
      default:    par_step = 12'h001;
    endcase
  endfunction

  // Stored value of the selected parameter
  logic [11:0] par_val;
  always_comb begin
    unique case (par_sel_r)
      3'h0:    par_val = gain_r;
      3'h1:    par_val = offset_r;
      3'h2:    par_val = rise_r;
      3'h3:    par_val = fall_r;
      default: par_val = pwm_r;
    endcase
  end

  // Key event decode
  logic both_now, both_rise, edit_enter, edit_leave, mod_enter;
  logic par_step_ev, val_inc, val_dec, val_store, var_next, name_brief;
  assign both_now    = key_one & key_two;
  assign both_rise   = ce & both_now & ~both_r;
  assign edit_enter  = (mode_r == VAK_VIEW) & k2_long;
  assign edit_leave  = (mode_r == VAK_EDIT) & k2_long;
  assign mod_enter   = (mode_r == VAK_EDIT) & k1_long & ~key_two;
  assign par_step_ev = (mode_r == VAK_EDIT) & k2_short & ~both_seen_r;
  assign val_inc     = (mode_r == VAK_MODIFY) & k2_short & ~both_seen_r;
  assign val_dec     = (mode_r == VAK_MODIFY) & k1_short & ~both_seen_r;
  assign val_store   = (mode_r == VAK_MODIFY) & both_rise;
  assign var_next    = (mode_r == VAK_VIEW) & k1_short;
  assign name_brief  = (mode_r == VAK_VIEW) & k2_short;

  // Mode sequencing; modify returns to edit only through a store
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      VAK_VIEW:   if (edit_enter) mode_nxt = VAK_EDIT;
      VAK_EDIT:   if (mod_enter) mode_nxt = VAK_MODIFY;
                  else if (edit_leave) mode_nxt = VAK_VIEW;
      VAK_MODIFY: if (val_store) mode_nxt = VAK_EDIT;
      default:    mode_nxt = VAK_VIEW;
    endcase
  end

  // Edited value with clamping at the parameter limits
  logic [11:0] edit_up, edit_dn;
  assign edit_up = (edit_r + par_step(par_sel_r) > par_hi(par_sel_r)) ?
                   par_hi(par_sel_r) : edit_r + par_step(par_sel_r);
  assign edit_dn = (edit_r < par_lo(par_sel_r) + par_step(par_sel_r)) ?
                   par_lo(par_sel_r) : edit_r - par_step(par_sel_r);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_r      <= VAK_VIEW;
      var_sel_r   <= 1'b0;
      par_sel_r   <= 3'h0;
      edit_r      <= 12'h000;
      both_r      <= 1'b0;
      both_seen_r <= 1'b0;
    end else if (ce) begin
      mode_r <= mode_nxt;
      both_r <= both_now;
      // Keys pressed together suppress the short-press actions of edit and modify modes on release
      if (both_now) begin
        both_seen_r <= 1'b1;
      end else if (!key_one && !key_two) begin
        both_seen_r <= 1'b0;
      end
      if (var_next) begin
        var_sel_r <= ~var_sel_r;
      end
      if (edit_enter) begin
        par_sel_r <= 3'h0;
      end else if (par_step_ev) begin
        par_sel_r <= (par_sel_r == 3'h4) ? 3'h0 : par_sel_r + 3'h1;
      end
      if (mod_enter) begin
        edit_r <= par_val;
      end else if (val_inc) begin
        edit_r <= edit_up;
      end else if (val_dec) begin
        edit_r <= edit_dn;
      end
    end
  end

  // Parameter store with version defaults
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gain_r   <= RATED_MAX_MA;
      offset_r <= 12'h000;
      rise_r   <= 12'h000;
      fall_r   <= 12'h000;
      pwm_r    <= {3'h0, PWM_DEFAULT_HZ};
    end else if (ce && val_store) begin
      unique case (par_sel_r)
        3'h0:    gain_r   <= edit_r;
        3'h1:    offset_r <= edit_r;
        3'h2:    rise_r   <= edit_r;
        3'h3:    fall_r   <= edit_r;
        default: pwm_r    <= edit_r;
      endcase
    end
  end

  // Cable break latches until power is removed; only reset clears it
  logic brk_now;
  assign brk_now = loop_mode & (loop_current_dma < LOOP_BREAK_DMA);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      err_r <= 1'b0;
    end else if (ce && brk_now) begin
      err_r <= 1'b1;
    end
  end

  // Name timer and blink phase, counted in ms ticks
  logic name_load;
  assign name_load = var_next | name_brief | edit_enter | par_step_ev;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      name_cnt_r  <= NAME_MS;
      blink_cnt_r <= 12'h000;
      blink_r     <= 1'b0;
    end else if (ce) begin
      if (name_load) begin
        name_cnt_r <= NAME_MS;
      end else if (tick && name_cnt_r != 12'h000) begin
        name_cnt_r <= name_cnt_r - 12'h001;
      end
      if (mode_r != VAK_MODIFY) begin
        blink_cnt_r <= 12'h000;
        blink_r     <= 1'b0;
      end else if (tick) begin
        blink_cnt_r <= (blink_cnt_r == BLINK_MS - 12'h001) ?
                       12'h000 : blink_cnt_r + 12'h001;
        if (blink_cnt_r == BLINK_MS - 12'h001) begin
          blink_r <= ~blink_r;
        end
      end
    end
  end

  // Current demand: offset above dead band, then proportional to gain
  logic [9:0]  ref_c;
  logic [21:0] span_prod;
  logic [11:0] target_ma;
  logic [21:0] target_ua;
  assign ref_c     = (ref_permil > REF_FULL) ? REF_FULL : ref_permil;
  assign span_prod = (gain_r > offset_r) ?
                     22'(gain_r - offset_r) * 22'(ref_c) : 22'h000000;
  assign target_ma = (ref_c > REF_DEAD) ?
                     offset_r + 12'(span_prod / 22'(REF_FULL)) : 12'h000;
  assign target_ua = 22'(target_ma) * 22'h0003E8;

  // Slope in uA per ms equals full-scale mA over ramp seconds
  logic [21:0] up_step, dn_step;
  assign up_step = (rise_r == 12'h000) ? 22'h000000 :
                   22'(gain_r / rise_r);
  assign dn_step = (fall_r == 12'h000) ? 22'h000000 :
                   22'(gain_r / fall_r);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sp_ua_r <= 22'h000000;
    end else if (ce) begin
      if (sp_ua_r < target_ua) begin
        if (rise_r == 12'h000 || target_ua - sp_ua_r <= up_step) begin
          sp_ua_r <= target_ua;
        end else if (tick) begin
          sp_ua_r <= sp_ua_r + up_step;
        end
      end else if (sp_ua_r > target_ua) begin
        if (fall_r == 12'h000 || sp_ua_r - target_ua <= dn_step) begin
          sp_ua_r <= target_ua;
        end else if (tick) begin
          sp_ua_r <= sp_ua_r - dn_step;
        end
      end
    end
  end

  // Display number selection; two digits and decimal point position
  logic [11:0] cur_ma;
  logic [6:0]  ref_disp, disp_num;
  logic [2:0]  name_sel;
  logic [11:0] show_val;
  assign cur_ma   = 12'(sp_ua_r / 22'h0003E8);
  assign ref_disp = loop_mode ?
    LOOP_DISP_BASE + 7'((17'(ref_c) * 17'(LOOP_DISP_SPAN)) / 17'(REF_FULL)) :
    7'(ref_c / 10'h00A);
  assign show_val = (mode_r == VAK_MODIFY) ? edit_r : par_val;
  assign name_sel = err_r ? NM_ERROR :
                    (mode_r == VAK_VIEW) ? {2'b00, var_sel_r} :
                    3'(par_sel_r + 3'h2);
  // Currents in tenths of an ampere, ramps in seconds, PWM in tens of Hz
  always_comb begin
    if (mode_r == VAK_VIEW) begin
      disp_num = var_sel_r ? 7'(cur_ma / 12'h064) : ref_disp;
    end else if (par_sel_r == 3'h4) begin
      disp_num = 7'(show_val / 12'h00A);
    end else if (par_sel_r < 3'h2) begin
      disp_num = 7'(show_val / 12'h064);
    end else begin
      disp_num = 7'(show_val);
    end
  end

  // Display registers; a full-scale reading of 100 shows as "10."
  logic is_ten, point_t;
  assign is_ten  = (mode_r == VAK_VIEW) & ~var_sel_r & (disp_num > 7'h63);
  assign point_t = ((mode_r == VAK_VIEW) | (par_sel_r < 3'h2)) & ~is_ten;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      disp_tens        <= 4'h0;
      disp_units       <= 4'h0;
      disp_point_tens  <= 1'b0;
      disp_point_units <= 1'b0;
      disp_show_name   <= 1'b1;
      disp_name        <= NM_REFERENCE;
      disp_blank       <= 1'b0;
    end else if (ce) begin
      disp_tens        <= is_ten ? 4'h1 : 4'(disp_num / 7'h0A);
      disp_units       <= is_ten ? 4'h0 : 4'(disp_num % 7'h0A);
      disp_point_tens  <= point_t;
      disp_point_units <= is_ten;
      disp_show_name   <= err_r | (name_cnt_r != 12'h000);
      disp_name        <= name_sel;
      disp_blank       <= blink_r;
    end
  end

  // Drive outputs; a cable break removes the coil drive
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      coil_current_ma <= 12'h000;
      pwm_freq_hz     <= PWM_DEFAULT_HZ;
      drive_enable    <= 1'b0;
    end else if (ce) begin
      coil_current_ma <= cur_ma;
      pwm_freq_hz     <= pwm_r[8:0];
      drive_enable    <= ~err_r;
    end
  end

  // Sticky events; a new event in the clearing cycle wins
  logic [EV_NUM-1:0] ev_set, st_clr;
  logic wr_status, wr_mask;
  assign ev_set[EV_BREAK]  = brk_now & ~err_r;
  assign ev_set[EV_STORED] = val_store;
  assign ev_set[EV_EDIT]   = edit_enter;
  assign wr_status = reg_wr & (reg_addr == ADDR_STATUS);
  assign wr_mask   = reg_wr & (reg_addr == ADDR_MASK);
  assign st_clr    = wr_status ? reg_wdata[EV_NUM-1:0] : '0;
  assign irq       = |(status_r & mask_r);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_r <= '0;
      mask_r   <= MASK_RESET;
    end else if (ce) begin
      status_r <= (status_r & ~st_clr) | ev_set;
      if (wr_mask) begin
        mask_r <= reg_wdata[EV_NUM-1:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      ADDR_STATUS: rd_mux = {29'h0, status_r};
      ADDR_MASK:   rd_mux = {29'h0, mask_r};
      ADDR_OUTPUT: rd_mux = {11'h0, pwm_freq_hz, coil_current_ma};
      ADDR_STATE:  rd_mux = {24'h0, err_r, par_sel_r, var_sel_r, mode_r};
      default:     rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

endmodule
